/* File: rtl/lpsc_top.sv */
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module lpsc_top
    import lpsc_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int READY_CYCLES = READY_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic frame_detected,
    input wire logic line_energy,
    output logic [DATA_W-1:0] rdata,
    output logic wake_pin,
    output logic mac_clk_en,
    output logic host_clk_en,
    output logic core_clk_en,
    output logic rxpm_clk_en,
    output logic frame_detect_en,
    output logic phy_powered,
    output logic phy_tx_en,
    output logic phy_reset,
    output logic line_energy_present
);
    if (PULSE_CYCLES < 1 || PULSE_CYCLES >= 2**27) begin : g_bad_pulse
        $error("PULSE_CYCLES out of range");
    end
    if (READY_CYCLES <= WAKE_LAT_CYC || READY_CYCLES >= 2**27) begin : g_bad_ready
        $error("READY_CYCLES out of range");
    end

    typedef struct packed {
        lpsc_mode_t mode;
        logic ready;
        logic read_seen;
        logic [1:0] pstate;
        logic [1:0] wsrc;
        logic frame_en;
        logic energy_en;
        logic pin_en;
        logic pulse_sel;
        logic int_wake;
        logic phy_pwrdn;
        logic phy_edpd;
        logic [26:0] pulse_cnt;
        logic [26:0] ready_cnt;
        logic pin;
        logic [DATA_W-1:0] rdata;
        lpsc_gate_t gate;
        logic wake_src_d;
    } lpsc_state_t;
    lpsc_state_t q;
    lpsc_state_t next_q;

    lpsc_bus_t bus;
    logic wake_pulse;
    logic energy_flag;
    logic flag_clr;
    logic wake_src;
    logic wr_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};
    assign wake_src = (q.wsrc == WS_FRAME && q.frame_en)
        || (q.wsrc == WS_ENERGY && q.energy_en);
    assign wr_ok = bus.wr && q.read_seen && q.ready;
    assign flag_clr = bus.rd && q.ready && is_reg(bus.addr, OFF_PHY_INTSRC);

    ////////////////////////////////////////////////////////////////////////////////
    // Submodules
    lpsc_wake_sync u_wake (
        .clk(clk),
        .rst(rst),
        .cs_n(cs_n),
        .wr_n(wr_n),
        .addr_hit(is_reg(bus.addr, OFF_WAKE_TEST)),
        .wake_pulse(wake_pulse)
    );

    lpsc_phy_power u_phy (
        .clk(clk),
        .rst(rst),
        .pwrdn_bit(q.phy_pwrdn),
        .edpd_bit(q.phy_edpd),
        .line_energy(line_energy),
        .flag_clr(flag_clr),
        .phy_powered(phy_powered),
        .phy_tx_en(phy_tx_en),
        .phy_reset(phy_reset),
        .line_energy_present(line_energy_present),
        .energy_flag(energy_flag)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_q = q;
        next_q.wake_src_d = wake_src;
        next_q.rdata = '0;
        if (bus.rd) begin
            next_q.read_seen = 1'b1;
            if (is_reg(bus.addr, OFF_PMCTRL)) begin
                next_q.rdata[PM_READY_BIT] = q.ready;
                next_q.rdata[PM_PIN_EN_BIT] = q.pin_en;
                next_q.rdata[PM_PULSE_SEL_BIT] = q.pulse_sel;
                next_q.rdata[PM_WSRC_LO +: 2] = q.wsrc;
                next_q.rdata[PM_FRAME_EN_BIT] = q.frame_en;
                next_q.rdata[PM_STATE_LO +: 2] = q.pstate;
                next_q.rdata[PM_ENERGY_EN_BIT] = q.energy_en;
            end else if (q.ready) begin
                if (is_reg(bus.addr, OFF_INT_STATUS)) begin
                    next_q.rdata[INT_WAKE_BIT] = q.int_wake;
                end else if (is_reg(bus.addr, OFF_PHY_CTRL)) begin
                    next_q.rdata[PHY_PWRDN_BIT] = q.phy_pwrdn;
                end else if (is_reg(bus.addr, OFF_PHY_MODE)) begin
                    next_q.rdata[PHY_EDPD_BIT] = q.phy_edpd;
                end else if (is_reg(bus.addr, OFF_PHY_INTSRC)) begin
                    next_q.rdata[PHY_ENERGY_FLAG_BIT] = energy_flag;
                end
            end
        end
        if (wr_ok) begin
            if (is_reg(bus.addr, OFF_PMCTRL)) begin
                next_q.pin_en = bus.wdata[PM_PIN_EN_BIT];
                next_q.pulse_sel = bus.wdata[PM_PULSE_SEL_BIT];
                next_q.frame_en = bus.wdata[PM_FRAME_EN_BIT];
                next_q.energy_en = bus.wdata[PM_ENERGY_EN_BIT];
                if (bus.wdata[PM_WSRC_LO +: 2] == WS_NONE) begin
                    next_q.wsrc = WS_NONE;
                end
                if (bus.wdata[PM_STATE_LO +: 2] == PS_LIGHT
                    || bus.wdata[PM_STATE_LO +: 2] == PS_DEEP) begin
                    next_q.pstate = bus.wdata[PM_STATE_LO +: 2];
                    next_q.mode = LPSC_SLEEP;
                    next_q.ready = 1'b0;
                    next_q.read_seen = 1'b0;
                end
            end else if (is_reg(bus.addr, OFF_INT_STATUS)) begin
                if (bus.wdata[INT_WAKE_BIT] && !wake_src) begin
                    next_q.int_wake = 1'b0;
                end
            end else if (is_reg(bus.addr, OFF_PHY_CTRL)) begin
                next_q.phy_pwrdn = bus.wdata[PHY_PWRDN_BIT];
            end else if (is_reg(bus.addr, OFF_PHY_MODE)) begin
                next_q.phy_edpd = bus.wdata[PHY_EDPD_BIT];
            end
        end
        case (q.mode)
            LPSC_RUN: begin
                next_q.ready_cnt = '0;
            end
            LPSC_SLEEP: begin
                if (q.pstate == PS_LIGHT && frame_detected) begin
                    next_q.wsrc = WS_FRAME;
                end
                if (q.pstate == PS_DEEP && line_energy) begin
                    next_q.wsrc = WS_ENERGY;
                end
                if (wake_pulse) begin
                    next_q.mode = LPSC_WAKING;
                    next_q.pstate = PS_NORMAL;
                    // Sync latency counted into the ready budget
                    next_q.ready_cnt = 27'(READY_CYCLES - WAKE_LAT_CYC);
                end
            end
            LPSC_WAKING: begin
                if (q.ready_cnt == '0) begin
                    next_q.ready = 1'b1;
                    next_q.mode = LPSC_RUN;
                end else begin
                    next_q.ready_cnt = q.ready_cnt - 27'h1;
                end
            end
            default: begin
                next_q.mode = LPSC_RUN;
            end
        endcase
        // Pin and status
        if (wake_src && !q.wake_src_d) begin
            next_q.int_wake = 1'b1;
            next_q.pulse_cnt = 27'(PULSE_CYCLES);
        end else if (q.pulse_cnt != '0) begin
            next_q.pulse_cnt = q.pulse_cnt - 27'h1;
        end
        next_q.pin = wake_src && q.pin_en
            && (!q.pulse_sel || next_q.pulse_cnt != '0);
        next_q.gate.mac_clk_en = next_q.pstate == PS_NORMAL;
        next_q.gate.host_clk_en = next_q.pstate == PS_NORMAL;
        next_q.gate.core_clk_en = next_q.pstate != PS_DEEP;
        next_q.gate.rxpm_clk_en = next_q.pstate != PS_DEEP;
        next_q.gate.frame_detect_en = next_q.pstate == PS_LIGHT;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; config survives sleep
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.mode <= LPSC_RUN;
            q.ready <= 1'b1;
            q.gate <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign rdata = q.rdata;
    assign wake_pin = q.pin;
    assign mac_clk_en = q.gate.mac_clk_en;
    assign host_clk_en = q.gate.host_clk_en;
    assign core_clk_en = q.gate.core_clk_en;
    assign rxpm_clk_en = q.gate.rxpm_clk_en;
    assign frame_detect_en = q.gate.frame_detect_en;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    // Sleep, wake and gating
    AST_SLEEP_NOT_READY: assert property (@(posedge clk) disable iff (rst)
        (q.mode == LPSC_SLEEP) |-> !q.ready)
        else $error("ready set in sleep");
    AST_WAKING_NOT_READY: assert property (@(posedge clk) disable iff (rst)
        (q.mode == LPSC_WAKING) |-> !q.ready)
        else $error("ready set while waking");
    AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (rst)
        (wr_ok && is_reg(bus.addr, OFF_PMCTRL)
        && (bus.wdata[PM_STATE_LO +: 2] == PS_LIGHT || bus.wdata[PM_STATE_LO +: 2] == PS_DEEP))
        |=> (!q.ready && !q.read_seen && q.mode == LPSC_SLEEP))
        else $error("sleep entry kept ready");
    AST_SLEEP_READ_ZERO: assert property (@(posedge clk) disable iff (rst)
        (rd && !q.ready && !is_reg(addr, OFF_PMCTRL)) |=> (rdata == '0))
        else $error("read while not ready returned data");
    AST_WAKE_MODE: assert property (@(posedge clk) disable iff (rst)
        (q.mode == LPSC_SLEEP && wake_pulse) |=> (q.mode == LPSC_WAKING))
        else $error("wake write not taken");
    AST_WAKE_STATE: assert property (@(posedge clk) disable iff (rst)
        (q.mode == LPSC_SLEEP && wake_pulse) |=> q.pstate == PS_NORMAL)
        else $error("wake did not reset state");
    AST_LIGHT_GATES: assert property (@(posedge clk) disable iff (rst)
        (q.pstate == PS_LIGHT) |-> (!mac_clk_en && core_clk_en && frame_detect_en))
        else $error("light sleep gating wrong");
    AST_DETECT_ONLY_LIGHT: assert property (@(posedge clk) disable iff (rst)
        (q.pstate != PS_LIGHT) |-> !frame_detect_en)
        else $error("frame detection outside light sleep");
    AST_DEEP_GATES: assert property (@(posedge clk) disable iff (rst)
        (q.pstate == PS_DEEP) |-> (!core_clk_en && !host_clk_en && !mac_clk_en))
        else $error("deep sleep gating wrong");
    AST_NO_WRITE_UNREAD: assert property (@(posedge clk) disable iff (rst)
        (!q.read_seen && wr && is_reg(addr, OFF_PMCTRL)) |=> $stable(q.pin_en))
        else $error("write before read taken");
    AST_CONFIG_KEPT: assert property (@(posedge clk) disable iff (rst)
        (q.mode != LPSC_RUN)
        |=> ($stable(q.pin_en) && $stable(q.frame_en) && $stable(q.energy_en)
        && $stable(q.pulse_sel) && $stable(q.phy_edpd) && $stable(q.phy_pwrdn)))
        else $error("configuration changed in sleep");
    AST_READY_BOUND: assert property (@(posedge clk) disable iff (rst)
        (q.mode == LPSC_WAKING && q.ready_cnt == '0) |=> q.ready)
        else $error("ready late");

    // Wake source, status and pin
    AST_FRAME_SRC: assert property (@(posedge clk) disable iff (rst)
        (q.mode == LPSC_SLEEP && q.pstate == PS_LIGHT && frame_detected && !wake_pulse)
        |=> q.wsrc == WS_FRAME) else $error("frame source not set");
    AST_FRAME_PIN: assert property (@(posedge clk) disable iff (rst)
        (q.wsrc == WS_FRAME && q.frame_en && q.pin_en && !q.pulse_sel) |=> wake_pin)
        else $error("frame wake pin not driven");
    AST_ENERGY_SRC: assert property (@(posedge clk) disable iff (rst)
        (q.mode == LPSC_SLEEP && q.pstate == PS_DEEP && line_energy && !wake_pulse)
        |=> q.wsrc == WS_ENERGY) else $error("energy source not set");
    AST_ENERGY_PIN: assert property (@(posedge clk) disable iff (rst)
        (q.wsrc == WS_ENERGY && q.energy_en && q.pin_en && !q.pulse_sel) |=> wake_pin)
        else $error("energy wake pin not driven");
    AST_INT_SET: assert property (@(posedge clk) disable iff (rst)
        (wake_src && !q.wake_src_d) |=> q.int_wake)
        else $error("status not set");
    AST_INT_HOLD: assert property (@(posedge clk) disable iff (rst)
        (q.int_wake && wake_src) |=> q.int_wake)
        else $error("status dropped while source active");
    AST_INT_CLEAR: assert property (@(posedge clk) disable iff (rst)
        (wr_ok && is_reg(bus.addr, OFF_INT_STATUS) && bus.wdata[INT_WAKE_BIT] && !wake_src)
        |=> !q.int_wake)
        else $error("status not cleared");
    AST_PULSE_END: assert property (@(posedge clk) disable iff (rst)
        (q.pulse_sel && q.pulse_cnt == '0 && !(wake_src && !q.wake_src_d)) |=> !wake_pin)
        else $error("pulse too long");
    AST_STATIC_PIN: assert property (@(posedge clk) disable iff (rst)
        (!q.pulse_sel && wake_src && q.pin_en) |=> wake_pin)
        else $error("static pin dropped");
    AST_PIN_DROP: assert property (@(posedge clk) disable iff (rst)
        (!wake_src || !q.pin_en) |=> !wake_pin)
        else $error("pin held");
    AST_WSRC_HELD: assert property (@(posedge clk) disable iff (rst)
        (q.wsrc != WS_NONE && !wr_ok) |=> (q.wsrc != WS_NONE))
        else $error("wake source lost");

    // PHY power
    AST_PHY_DOWN: assert property (@(posedge clk) disable iff (rst)
        q.phy_pwrdn |=> !phy_powered)
        else $error("PHY powered while down");
    AST_PHY_RESET: assert property (@(posedge clk) disable iff (rst)
        $fell(q.phy_pwrdn) |=> phy_reset)
        else $error("PHY not reset on power up");
    AST_EDPD_QUIET: assert property (@(posedge clk) disable iff (rst)
        (q.phy_edpd && !line_energy) |=> (!phy_powered && !phy_tx_en))
        else $error("PHY active without line energy");
    AST_ENERGY_FLAG: assert property (@(posedge clk) disable iff (rst)
        (q.phy_edpd && $rose(line_energy)) |=> energy_flag)
        else $error("energy flag not set");
endmodule

/* File: pkg/lpsc_pkg.sv */
package lpsc_pkg;
    // Register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_PMCTRL = 8'h54;
    localparam logic [7:0] OFF_WAKE_TEST = 8'h64;
    localparam logic [7:0] OFF_INT_STATUS = 8'h58;
    localparam logic [7:0] OFF_PHY_CTRL = 8'hA0;
    localparam logic [7:0] OFF_PHY_MODE = 8'hA4;
    localparam logic [7:0] OFF_PHY_INTSRC = 8'hA8;
    // Power control register fields
    localparam int PM_READY_BIT = 0;
    localparam int PM_PIN_EN_BIT = 1;
    localparam int PM_PULSE_SEL_BIT = 3;
    localparam int PM_WSRC_LO = 4;
    localparam int PM_FRAME_EN_BIT = 9;
    localparam int PM_ENERGY_EN_BIT = 14;
    localparam int PM_STATE_LO = 12;
    // Interrupt status field
    localparam int INT_WAKE_BIT = 17;
    // PHY fields
    localparam int PHY_PWRDN_BIT = 11;
    localparam int PHY_EDPD_BIT = 13;
    localparam int PHY_ENERGY_FLAG_BIT = 1;
    // Encodings
    localparam logic [1:0] PS_NORMAL = 2'h0;
    localparam logic [1:0] PS_LIGHT = 2'h1;
    localparam logic [1:0] PS_DEEP = 2'h2;
    localparam logic [1:0] WS_NONE = 2'h0;
    localparam logic [1:0] WS_ENERGY = 2'h1;
    localparam logic [1:0] WS_FRAME = 2'h2;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int PULSE_MS = 50;
    localparam int READY_MS = 2;
    localparam int PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
    localparam int READY_CYC = READY_MS * 1000 * CLK_MHZ;
    localparam int PHY_RESET_CYC = 16;
    localparam int WAKE_LAT_CYC = 4;

    typedef enum {LPSC_RUN, LPSC_SLEEP, LPSC_WAKING} lpsc_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } lpsc_bus_t;

    typedef struct packed {
        logic mac_clk_en;
        logic host_clk_en;
        logic core_clk_en;
        logic rxpm_clk_en;
        logic frame_detect_en;
    } lpsc_gate_t;
endpackage

/* File: rtl/lpsc_wake_sync.sv */
`timescale 1ns/1ps
module lpsc_wake_sync
    import lpsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic addr_hit,
    output logic wake_pulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } lpsc_sync_t;
    lpsc_sync_t q;
    lpsc_sync_t next_q;
    logic raw;

    // Strobe decode without a clock
    assign raw = !cs_n && !wr_n && addr_hit;

    always_comb begin
        next_q = q;
        next_q.s1 = raw;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign wake_pulse = q.s2 && !q.s3;
endmodule

/* File: rtl/lpsc_phy_power.sv */
`timescale 1ns/1ps
module lpsc_phy_power
    import lpsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pwrdn_bit,
    input wire logic edpd_bit,
    input wire logic line_energy,
    input wire logic flag_clr,
    output logic phy_powered,
    output logic phy_tx_en,
    output logic phy_reset,
    output logic line_energy_present,
    output logic energy_flag
);
    typedef struct packed {
        logic pwrdn_d;
        logic [7:0] rst_cnt;
        logic energy_d;
        logic flag;
        logic powered;
        logic tx_en;
        logic reset_out;
    } lpsc_phy_t;
    lpsc_phy_t q;
    lpsc_phy_t next_q;

    always_comb begin
        next_q = q;
        next_q.pwrdn_d = pwrdn_bit;
        next_q.energy_d = line_energy;
        if (q.pwrdn_d && !pwrdn_bit) begin
            next_q.rst_cnt = 8'(PHY_RESET_CYC);
        end else if (q.rst_cnt != 8'h00) begin
            next_q.rst_cnt = q.rst_cnt - 8'h01;
        end
        if (flag_clr) begin
            next_q.flag = 1'b0;
        end
        if (edpd_bit && line_energy && !q.energy_d) begin
            next_q.flag = 1'b1;
        end
        next_q.powered = !pwrdn_bit && (!edpd_bit || line_energy);
        next_q.tx_en = next_q.powered && (next_q.rst_cnt == 8'h00);
        next_q.reset_out = next_q.rst_cnt != 8'h00;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign line_energy_present = q.energy_d;
    assign phy_powered = q.powered;
    assign phy_tx_en = q.tx_en;
    assign phy_reset = q.reset_out;
    assign energy_flag = q.flag;
endmodule

/* File: dv/lpsc_host.sv */
`timescale 1ns/1ps
module lpsc_host
    import lpsc_pkg::*;
(
    input wire logic clk,
    input wire logic [DATA_W-1:0] rdata,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] wdata,
    output logic wr,
    output logic rd,
    output logic cs_n,
    output logic wr_n
);
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'h0;
        rd = 1'h0;
        cs_n = 1'h1;
        wr_n = 1'h1;
    end
    ////////////////////////////////////////////////////////////////
    // One-cycle write, data inverted once released
    task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        wdata <= ~d;
    endtask
    // One-cycle read, data taken in the following cycle
    task automatic get(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        d = rdata;
    endtask
    // Wake write on raw pins, the only write while not ready
    task automatic wake();
        @(posedge clk);
        addr <= OFF_WAKE_TEST;
        wdata <= 32'h0000_0000;
        cs_n <= 1'h0;
        wr_n <= 1'h0;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        @(posedge clk);
        cs_n <= 1'h1;
        wr_n <= 1'h1;
        wdata <= 32'hFFFF_FFFF;
    endtask
endmodule

/* File: dv/lan_power_state_control_bench.sv */
`timescale 1ns/1ps
module lan_power_state_control_bench
    import lpsc_pkg::*;
;
    localparam int PC = 20;
    localparam int RC = 10;
    localparam logic [31:0] M_INT = 32'h0002_0000;
    logic clk, rst, wr, rd, cs_n, wr_n, frame_detected, line_energy;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic wake_pin, mac_clk_en, host_clk_en, core_clk_en, rxpm_clk_en, frame_detect_en;
    logic phy_powered, phy_tx_en, phy_reset, line_energy_present;
    int err_total = 0;
    int tests_run = 0;

    lpsc_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .cs_n(cs_n), .wr_n(wr_n));
    lpsc_top #(.PULSE_CYCLES(PC), .READY_CYCLES(RC)) uut (.clk(clk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .cs_n(cs_n), .wr_n(wr_n),
        .frame_detected(frame_detected), .line_energy(line_energy), .rdata(rdata),
        .wake_pin(wake_pin), .mac_clk_en(mac_clk_en), .host_clk_en(host_clk_en),
        .core_clk_en(core_clk_en), .rxpm_clk_en(rxpm_clk_en),
        .frame_detect_en(frame_detect_en), .phy_powered(phy_powered),
        .phy_tx_en(phy_tx_en), .phy_reset(phy_reset),
        .line_energy_present(line_energy_present));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    // Helpers
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input bit ok, input string m);
        tests_run++;
        if (!ok) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        host.get(a, d);
        chk((d & m) === e, "read field mismatch");
    endtask
    // Bounded wait on wake pin (sel 0) or PHY reset (sel 1)
    task automatic wait_on(input int sel, input logic v, input int n);
        for (int i = 0; i < n; i++) begin
            step(1);
            if ((sel == 0 ? wake_pin : phy_reset) === v) return;
        end
        chk(1'b0, "output never reached level");
        close_out();
    endtask
    task automatic wait_ready();
        logic [31:0] d;
        realtime t0;
        t0 = $realtime;
        for (int i = 0; i < RC + 20; i++) begin
            host.get(OFF_PMCTRL, d);
            if (d[PM_READY_BIT] === 1'b1) begin
                chk(($realtime - t0) <= (RC + 1) * 10.0, "ready late");
                return;
            end
        end
        chk(1'b0, "ready never set");
        close_out();
    endtask
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        chk({mac_clk_en, host_clk_en, core_clk_en, rxpm_clk_en, frame_detect_en,
            wake_pin} === 6'h3C, "reset outputs");
        host.put(OFF_PMCTRL, 32'h0000_0002);
        rchk(OFF_PMCTRL, 32'h0000_300B, 32'h0000_0001);
        $display("test reset done");
    endtask
    task automatic t_light();
        host.put(OFF_PMCTRL, 32'h0000_120A);
        step(3);
        chk({mac_clk_en, host_clk_en, core_clk_en, rxpm_clk_en, frame_detect_en}
            === 5'h07, "light sleep gating");
        rchk(OFF_PMCTRL, 32'h0000_0001, 32'h0000_0000);
        rchk(OFF_INT_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        @(posedge clk) frame_detected <= 1'h1;
        @(posedge clk) frame_detected <= 1'h0;
        wait_on(0, 1'h1, 10);
        begin
            int n;
            n = 1;
            while (wake_pin === 1'h1 && n < 3 * PC) begin
                step(1);
                n++;
            end
            chk(n >= PC - 1 && n <= PC + 1, "pulse length");
        end
        rchk(OFF_PMCTRL, 32'h0000_0030, 32'h0000_0020);
        host.wake();
        wait_ready();
        rchk(OFF_PMCTRL, 32'h0000_320A, 32'h0000_020A);
        chk({mac_clk_en, host_clk_en, core_clk_en} === 3'h7, "clocks back");
        rchk(OFF_INT_STATUS, M_INT, M_INT);
        host.put(OFF_INT_STATUS, M_INT);
        rchk(OFF_INT_STATUS, M_INT, M_INT);
        host.put(OFF_PMCTRL, 32'h0000_020A);
        host.put(OFF_INT_STATUS, M_INT);
        rchk(OFF_INT_STATUS, M_INT, 32'h0000_0000);
        $display("test light sleep done");
    endtask
    task automatic t_deep();
        host.put(OFF_PHY_MODE, 32'h0000_2000);
        step(2);
        chk({phy_tx_en, phy_powered} === 2'h0, "energy powerdown idle");
        @(posedge clk) line_energy <= 1'h1;
        step(3);
        chk({phy_powered, line_energy_present} === 2'h3, "energy arrival");
        rchk(OFF_PHY_INTSRC, 32'h0000_0002, 32'h0000_0002);
        host.put(OFF_PMCTRL, 32'h0000_6002);
        step(3);
        chk({mac_clk_en, host_clk_en, core_clk_en} === 3'h0, "deep gating");
        wait_on(0, 1'h1, 10);
        rchk(OFF_PMCTRL, 32'h0000_0030, 32'h0000_0010);
        step(2 * PC);
        chk(wake_pin === 1'h1, "static pin dropped");
        host.wake();
        wait_ready();
        rchk(OFF_INT_STATUS, M_INT, M_INT);
        host.put(OFF_PMCTRL, 32'h0000_0002);
        wait_on(0, 1'h0, 6);
        host.put(OFF_PHY_MODE, 32'h0000_0000);
        $display("test deep sleep done");
    endtask
    task automatic t_pwrdn();
        host.put(OFF_PHY_CTRL, 32'h0000_0800);
        step(2);
        chk(phy_powered === 1'h0, "general powerdown");
        host.put(OFF_PHY_CTRL, 32'h0000_0000);
        wait_on(1, 1'h1, PHY_RESET_CYC + 5);
        wait_on(1, 1'h0, PHY_RESET_CYC + 5);
        chk(phy_tx_en === 1'h1, "transmit back after reset");
        $display("test phy powerdown done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'h1;
        frame_detected = 1'h0;
        line_energy = 1'h0;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        step(1);
        t_reset();
        t_light();
        t_deep();
        t_pwrdn();
        close_out();
    end
endmodule
